/* core/fmam_consts.vh */
`ifndef FMAM_CONSTS_VH
`define FMAM_CONSTS_VH
// attribute identifiers used as register addresses
`define FMAM_ATTR_UNITS        8'h04
`define FMAM_ATTR_FLOW         8'h06
`define FMAM_ATTR_ALM_HI       8'h11
`define FMAM_ATTR_ALM_LO       8'h12
`define FMAM_ATTR_ALM_HYS      8'h13
`define FMAM_ATTR_ALM_SET      8'h14
`define FMAM_ATTR_WRN_HI       8'h15
`define FMAM_ATTR_WRN_LO       8'h16
`define FMAM_ATTR_WRN_HYS      8'h17
`define FMAM_ATTR_WRN_SET      8'h18
`define FMAM_ATTR_CAL_SEL      8'h23
`define FMAM_ATTR_FLOW_HOURS   8'h60
`define FMAM_ATTR_ZERO_DUR     8'h69
`define FMAM_ATTR_ZERO_START   8'h70
`define FMAM_ATTR_TOT_UNITS    8'h7D
// reset values
`define FMAM_UNITS_PERCENT     16'h1007
`define FMAM_RST_ZERO32        32'h00000000
`define FMAM_RST_ZERO_DUR      32'h000003E8
`define FMAM_RST_SETTLE        32'h00000000
// timing: one millisecond at the core clock
`define FMAM_CLK_HZ            25000000
`define FMAM_MS_PER_S          1000
`define FMAM_SEC_PER_HOUR      3600
`endif

/* core/fmam_monitor.v */
`include "fmam_consts.vh"
module fmam_monitor #(
  // MS_CYCLES and HOUR_MS may shrink in simulation to keep runs short
  parameter integer CLK_HZ      = `FMAM_CLK_HZ,
  parameter integer MS_CYCLES   = CLK_HZ / `FMAM_MS_PER_S,
  parameter integer HOUR_MS     = `FMAM_SEC_PER_HOUR * `FMAM_MS_PER_S
) (
  input  wire        CORE_CLK_IN,
  input  wire        SRST_IN,
  input  wire [31:0] SAMPLE_FLOW_IN,
  input  wire        SAMPLE_VALID_IN,
  input  wire        ZERO_INHIBIT_IN,
  input  wire        ATTR_WR_IN,
  input  wire        ATTR_RD_IN,
  input  wire [7:0]  ATTR_ID_IN,
  input  wire [31:0] ATTR_WDATA_IN,
  output reg  [31:0] ATTR_RDATA_OUT,
  output reg         ATTR_RVALID_OUT,
  output reg         ATTR_ERR_OUT,
  output reg         ALARM_OUT,
  output reg         WARNING_OUT,
  output reg         ZERO_ACTIVE_OUT,
  output reg  [31:0] CAL_SELECT_OUT,
  output reg  [15:0] UNITS_SELECT_OUT
);

  // attribute storage: latest calibrated sample
  reg [31:0] flow_value;
  // trip, hysteresis and settling settings
  reg [31:0] alarm_high_trip;
  reg [31:0] alarm_low_trip;
  reg [31:0] alarm_hysteresis;
  reg [31:0] alarm_settle_ms;
  reg [31:0] warning_high_trip;
  reg [31:0] warning_low_trip;
  reg [31:0] warning_hysteresis;
  reg [31:0] warning_settle_ms;
  // zero duration, totalizer units and flow hours
  reg [31:0] zero_duration_ms;
  reg [31:0] totalizer_units_select;
  reg [31:0] flow_hour_count;
  reg        sample_seen;

  // millisecond tick shared by all timers
  reg [31:0] ms_div;
  wire       ms_tick = (ms_div == MS_CYCLES - 1);

  // settling timers and zero timer, in milliseconds
  // hour_ms gathers flowing milliseconds before they roll into an hour
  reg [31:0] alarm_timer;
  reg [31:0] warning_timer;
  reg [31:0] zero_timer;
  reg [31:0] hour_ms;

  // signed flow comparisons against trips
  // clear points are worked out one bit wider, so that a trip near the
  // end of the range minus or plus a hysteresis cannot wrap around and
  // leave a latched condition stuck or cleared by mistake
  wire signed [31:0] flow_s   = $signed(flow_value);
  wire signed [32:0] a_hi_clr = $signed({alarm_high_trip[31], alarm_high_trip})
                                - $signed({alarm_hysteresis[31], alarm_hysteresis});
  wire signed [32:0] a_lo_clr = $signed({alarm_low_trip[31], alarm_low_trip})
                                + $signed({alarm_hysteresis[31], alarm_hysteresis});
  wire signed [32:0] w_hi_clr = $signed({warning_high_trip[31], warning_high_trip})
                                - $signed({warning_hysteresis[31], warning_hysteresis});
  wire signed [32:0] w_lo_clr = $signed({warning_low_trip[31], warning_low_trip})
                                + $signed({warning_hysteresis[31], warning_hysteresis});
  wire signed [32:0] flow_w   = {flow_s[31], flow_s};

  // beyond a trip point: the raising side
  wire alarm_beyond = (flow_s > $signed(alarm_high_trip))
                   || (flow_s < $signed(alarm_low_trip));
  wire warn_beyond  = (flow_s > $signed(warning_high_trip))
                   || (flow_s < $signed(warning_low_trip));
  // back inside by the hysteresis: the clearing side
  wire alarm_clear  = (flow_w <= a_hi_clr) && (flow_w >= a_lo_clr);
  wire warn_clear   = (flow_w <= w_hi_clr) && (flow_w >= w_lo_clr);
  // any non-zero flow counts toward flow hours
  wire flowing      = (flow_value != `FMAM_RST_ZERO32);

  // zero start request decoded from an attribute write
  // an inhibited start is dropped, not held for later
  // only bit 0 of the written word matters
  wire zero_req = ATTR_WR_IN && (ATTR_ID_IN == `FMAM_ATTR_ZERO_START)
                  && ATTR_WDATA_IN[0] && !ZERO_INHIBIT_IN;

  // attribute writes and flow sample capture
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      UNITS_SELECT_OUT       <= `FMAM_UNITS_PERCENT;
      flow_value             <= `FMAM_RST_ZERO32;
      alarm_high_trip        <= `FMAM_RST_ZERO32;
      alarm_low_trip         <= `FMAM_RST_ZERO32;
      alarm_hysteresis       <= `FMAM_RST_ZERO32;
      alarm_settle_ms        <= `FMAM_RST_SETTLE;
      warning_high_trip      <= `FMAM_RST_ZERO32;
      warning_low_trip       <= `FMAM_RST_ZERO32;
      warning_hysteresis     <= `FMAM_RST_ZERO32;
      warning_settle_ms      <= `FMAM_RST_SETTLE;
      CAL_SELECT_OUT         <= `FMAM_RST_ZERO32;
      zero_duration_ms       <= `FMAM_RST_ZERO_DUR;
      totalizer_units_select <= `FMAM_RST_ZERO32;
      sample_seen            <= 1'b0;
    end
    else
    begin
      // capture each new calibrated sample, decide one edge later
      sample_seen <= SAMPLE_VALID_IN;
      if (SAMPLE_VALID_IN)
        flow_value <= SAMPLE_FLOW_IN;
      // flow and flow hours are read-only: writes to them fall through
      // unknown ids fall through as well and change nothing
      if (ATTR_WR_IN)
      begin
        if (ATTR_ID_IN == `FMAM_ATTR_UNITS)
          UNITS_SELECT_OUT <= ATTR_WDATA_IN[15:0];
        // alarm trip settings
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_HI)
          alarm_high_trip <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_LO)
          alarm_low_trip <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_HYS)
          alarm_hysteresis <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_SET)
          alarm_settle_ms <= ATTR_WDATA_IN;
        // warning trip settings
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_HI)
          warning_high_trip <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_LO)
          warning_low_trip <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_HYS)
          warning_hysteresis <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_SET)
          warning_settle_ms <= ATTR_WDATA_IN;
        // calibration, zero and totalizer settings
        else if (ATTR_ID_IN == `FMAM_ATTR_CAL_SEL)
          CAL_SELECT_OUT <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_ZERO_DUR)
          zero_duration_ms <= ATTR_WDATA_IN;
        else if (ATTR_ID_IN == `FMAM_ATTR_TOT_UNITS)
          totalizer_units_select <= ATTR_WDATA_IN;
      end
    end
  end

  // free running millisecond divider
  // one shared tick keeps all timers in step; each timer therefore starts
  // somewhere inside a millisecond and may run short by up to one tick
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      ms_div <= `FMAM_RST_ZERO32;
    else if (ms_tick)
      ms_div <= `FMAM_RST_ZERO32;
    else
      ms_div <= ms_div + 32'h00000001;
  end

  // alarm settling and latch, evaluated on each new sample
  // the timer restarts whenever flow is back inside, so an excursion spanning
  // fewer millisecond ticks than the settling time never raises the alarm;
  // it saturates at the settling time
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      alarm_timer <= `FMAM_RST_ZERO32;
      ALARM_OUT   <= 1'b0;
    end
    else
    begin
      if (!alarm_beyond || ALARM_OUT)
        alarm_timer <= `FMAM_RST_ZERO32;
      else if (ms_tick && alarm_timer < alarm_settle_ms)
        alarm_timer <= alarm_timer + 32'h00000001;
      // set and clear are only decided on a sample
      if (sample_seen)
      begin
        if (!ALARM_OUT && alarm_beyond && alarm_timer >= alarm_settle_ms)
          ALARM_OUT <= 1'b1;
        else if (ALARM_OUT && alarm_clear)
          ALARM_OUT <= 1'b0;
      end
    end
  end

  // warning settling and latch, evaluated on each new sample
  // same scheme as the alarm, with its own trips, hysteresis and timer
  // so that the two conditions settle independently
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      warning_timer <= `FMAM_RST_ZERO32;
      WARNING_OUT   <= 1'b0;
    end
    else
    begin
      if (!warn_beyond || WARNING_OUT)
        warning_timer <= `FMAM_RST_ZERO32;
      else if (ms_tick && warning_timer < warning_settle_ms)
        warning_timer <= warning_timer + 32'h00000001;
      // set and clear are only decided on a sample
      if (sample_seen)
      begin
        if (!WARNING_OUT && warn_beyond && warning_timer >= warning_settle_ms)
          WARNING_OUT <= 1'b1;
        else if (WARNING_OUT && warn_clear)
          WARNING_OUT <= 1'b0;
      end
    end
  end

  // zero operation timer
  // a start while a zero runs is ignored, so the duration is never extended
  // a zero duration of 0 ends on the first tick, behaving as 1 ms
  // the operation ends on the tick where the count reaches the duration
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      zero_timer      <= `FMAM_RST_ZERO32;
      ZERO_ACTIVE_OUT <= 1'b0;
    end
    else if (!ZERO_ACTIVE_OUT)
    begin
      // idle: wait for an accepted start
      if (zero_req)
      begin
        ZERO_ACTIVE_OUT <= 1'b1;
        zero_timer      <= `FMAM_RST_ZERO32;
      end
    end
    else if (ms_tick)
    begin
      if (zero_timer + 32'h00000001 >= zero_duration_ms)
        ZERO_ACTIVE_OUT <= 1'b0;
      zero_timer <= zero_timer + 32'h00000001;
    end
  end

  // flow hours: count milliseconds with flow, roll into hours
  // partial hours are kept across pauses in flow, lost only on reset
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      hour_ms         <= `FMAM_RST_ZERO32;
      flow_hour_count <= `FMAM_RST_ZERO32;
    end
    else if (ms_tick && flowing)
    begin
      // one full hour of flowing milliseconds
      if (hour_ms == HOUR_MS - 1)
      begin
        hour_ms         <= `FMAM_RST_ZERO32;
        flow_hour_count <= flow_hour_count + 32'h00000001;
      end
      else
        hour_ms <= hour_ms + 32'h00000001;
    end
  end

  // attribute reads, answered one cycle later
  // data and error stand for exactly the one cycle that the answer stands
  // an unknown id answers zero data with the error flag
  always @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      ATTR_RDATA_OUT  <= `FMAM_RST_ZERO32;
      ATTR_RVALID_OUT <= 1'b0;
      ATTR_ERR_OUT    <= 1'b0;
    end
    else
    begin
      // answer defaults to zero data, no error
      ATTR_RVALID_OUT <= ATTR_RD_IN;
      ATTR_ERR_OUT    <= 1'b0;
      ATTR_RDATA_OUT  <= `FMAM_RST_ZERO32;
      if (ATTR_RD_IN)
      begin
        if (ATTR_ID_IN == `FMAM_ATTR_UNITS)
          ATTR_RDATA_OUT <= {16'h0000, UNITS_SELECT_OUT};
        else if (ATTR_ID_IN == `FMAM_ATTR_FLOW)
          ATTR_RDATA_OUT <= flow_value;
        // alarm trip settings
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_HI)
          ATTR_RDATA_OUT <= alarm_high_trip;
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_LO)
          ATTR_RDATA_OUT <= alarm_low_trip;
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_HYS)
          ATTR_RDATA_OUT <= alarm_hysteresis;
        else if (ATTR_ID_IN == `FMAM_ATTR_ALM_SET)
          ATTR_RDATA_OUT <= alarm_settle_ms;
        // warning trip settings
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_HI)
          ATTR_RDATA_OUT <= warning_high_trip;
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_LO)
          ATTR_RDATA_OUT <= warning_low_trip;
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_HYS)
          ATTR_RDATA_OUT <= warning_hysteresis;
        else if (ATTR_ID_IN == `FMAM_ATTR_WRN_SET)
          ATTR_RDATA_OUT <= warning_settle_ms;
        // calibration, hours, zero and totalizer
        else if (ATTR_ID_IN == `FMAM_ATTR_CAL_SEL)
          ATTR_RDATA_OUT <= CAL_SELECT_OUT;
        else if (ATTR_ID_IN == `FMAM_ATTR_FLOW_HOURS)
          ATTR_RDATA_OUT <= flow_hour_count;
        else if (ATTR_ID_IN == `FMAM_ATTR_ZERO_DUR)
          ATTR_RDATA_OUT <= zero_duration_ms;
        else if (ATTR_ID_IN == `FMAM_ATTR_ZERO_START)
          ATTR_RDATA_OUT <= {31'h00000000, ZERO_ACTIVE_OUT};
        else if (ATTR_ID_IN == `FMAM_ATTR_TOT_UNITS)
          ATTR_RDATA_OUT <= totalizer_units_select;
        else
          ATTR_ERR_OUT <= 1'b1;                                // unknown attribute
      end
    end
  end

endmodule

/* verif/fmam_scanner.sv */
// remote scanner: issues one attribute access at a time on the falling edge
module fmam_scanner (
  input  wire         clk_in,
  input  wire  [31:0] rdata_in,
  input  wire         err_in,
  output logic        wr_out,
  output logic        rd_out,
  output logic [7:0]  id_out,
  output logic [31:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial
  begin
    {wr_out, rd_out, id_out, wdata_out} = '0;
  end
  // one write strobe, then lines are scrambled so stale data never looks valid
  task automatic wr(input logic [7:0] id, input logic [31:0] d);
    @(negedge clk_in);
    wr_out = 1'b1;
    id_out = id;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    id_out = ~id;
    wdata_out = ~d;
  endtask
  // one read strobe; the answer is taken in the single cycle it stands
  task automatic rd(input logic [7:0] id, output logic [31:0] d, output logic e);
    @(negedge clk_in);
    rd_out = 1'b1;
    id_out = id;
    @(negedge clk_in);
    rd_out = 1'b0;
    id_out = ~id;
    d = rdata_in;
    e = err_in;
  endtask
endmodule

/* verif/fmam_monitor_sva.sv */
`include "fmam_consts.vh"
module fmam_monitor_sva (
  input wire        CORE_CLK_IN,
  input wire        SRST_IN,
  input wire        SAMPLE_VALID_IN,
  input wire        ZERO_INHIBIT_IN,
  input wire        ATTR_WR_IN,
  input wire        ATTR_RD_IN,
  input wire [7:0]  ATTR_ID_IN,
  input wire [31:0] ATTR_WDATA_IN,
  input wire        ATTR_RVALID_OUT,
  input wire        ALARM_OUT,
  input wire        WARNING_OUT,
  input wire        ZERO_ACTIVE_OUT,
  input wire [31:0] CAL_SELECT_OUT,
  input wire [15:0] UNITS_SELECT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (SRST_IN);
  // read request, its answer, and a zero start request
  sequence s_rd; ATTR_RD_IN; endsequence
  sequence s_ans; ATTR_RVALID_OUT; endsequence
  sequence s_zgo; ATTR_WR_IN && ATTR_ID_IN == `FMAM_ATTR_ZERO_START && ATTR_WDATA_IN[0]; endsequence
  property p_read; s_rd |=> s_ans; endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_cause; s_ans |-> $past(ATTR_RD_IN); endproperty
  a_cause: assert property (p_cause) else $error("answer without read");
  property p_units_rst; $fell(SRST_IN) |-> UNITS_SELECT_OUT == `FMAM_UNITS_PERCENT; endproperty
  a_units_rst: assert property (p_units_rst) else $error("units not percent");
  property p_units_wr; ATTR_WR_IN && ATTR_ID_IN == `FMAM_ATTR_UNITS
    |=> UNITS_SELECT_OUT == $past(ATTR_WDATA_IN[15:0]); endproperty
  a_units_wr: assert property (p_units_wr) else $error("units not written");
  property p_cal_wr; ATTR_WR_IN && ATTR_ID_IN == `FMAM_ATTR_CAL_SEL
    |=> CAL_SELECT_OUT == $past(ATTR_WDATA_IN); endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("calibration not written");
  property p_zero_go; s_zgo ##0 (!ZERO_INHIBIT_IN && !ZERO_ACTIVE_OUT) |=> ZERO_ACTIVE_OUT;
  endproperty
  a_zero_go: assert property (p_zero_go) else $error("zero not started");
  property p_zero_block; s_zgo ##0 (ZERO_INHIBIT_IN && !ZERO_ACTIVE_OUT) |=> !ZERO_ACTIVE_OUT;
  endproperty
  a_zero_block: assert property (p_zero_block) else $error("zero started inhibited");
  property p_alarm_when; $changed(ALARM_OUT) && !$past(SRST_IN) |-> $past(SAMPLE_VALID_IN, 2);
  endproperty
  a_alarm_when: assert property (p_alarm_when) else $error("alarm moved off sample");
  property p_warn_when; $changed(WARNING_OUT) && !$past(SRST_IN) |-> $past(SAMPLE_VALID_IN, 2);
  endproperty
  a_warn_when: assert property (p_warn_when) else $error("warning moved off sample");
endmodule
bind fmam_monitor fmam_monitor_sva chk_u (.CORE_CLK_IN(CORE_CLK_IN), .SRST_IN(SRST_IN),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .ZERO_INHIBIT_IN(ZERO_INHIBIT_IN), .ATTR_WR_IN(ATTR_WR_IN),
  .ATTR_RD_IN(ATTR_RD_IN), .ATTR_ID_IN(ATTR_ID_IN), .ATTR_WDATA_IN(ATTR_WDATA_IN),
  .ATTR_RVALID_OUT(ATTR_RVALID_OUT), .ALARM_OUT(ALARM_OUT), .WARNING_OUT(WARNING_OUT),
  .ZERO_ACTIVE_OUT(ZERO_ACTIVE_OUT), .CAL_SELECT_OUT(CAL_SELECT_OUT),
  .UNITS_SELECT_OUT(UNITS_SELECT_OUT));

/* verif/fmam_monitor_bench.sv */
`include "fmam_consts.vh"
module fmam_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 4;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] flow = 32'h0;
  logic        sv = 1'b0;
  logic        inh = 1'b0;
  wire         wr, rd, err, alarm, warn, zact, rv;
  wire  [7:0]  id;
  wire  [31:0] wd, rdata, cal;
  wire  [15:0] units;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n, c0;
  logic [31:0] seed = 32'h0000004A;
  logic [31:0] got, h0;
  logic        e, a;
  logic [7:0]  ids [11] = '{`FMAM_ATTR_ALM_HI, `FMAM_ATTR_ALM_LO, `FMAM_ATTR_ALM_HYS,
    `FMAM_ATTR_ALM_SET, `FMAM_ATTR_WRN_HI, `FMAM_ATTR_WRN_LO, `FMAM_ATTR_WRN_HYS,
    `FMAM_ATTR_WRN_SET, `FMAM_ATTR_ZERO_DUR, `FMAM_ATTR_CAL_SEL, `FMAM_ATTR_TOT_UNITS};
  int          cfg [9] = '{100, -100, 10, 0, 50, -50, 5, 3, 3};
  int          corner [8] = '{101, 95, 91, 90, -101, -95, -90, 0};
  always #20 clk = ~clk;
  fmam_scanner sc_u (.clk_in(clk), .rdata_in(rdata), .err_in(err), .wr_out(wr), .rd_out(rd),
    .id_out(id), .wdata_out(wd));
  fmam_monitor #(.MS_CYCLES(MS), .HOUR_MS(3)) dut_u (.CORE_CLK_IN(clk), .SRST_IN(srst),
    .SAMPLE_FLOW_IN(flow), .SAMPLE_VALID_IN(sv), .ZERO_INHIBIT_IN(inh), .ATTR_WR_IN(wr),
    .ATTR_RD_IN(rd), .ATTR_ID_IN(id), .ATTR_WDATA_IN(wd), .ATTR_RDATA_OUT(rdata),
    .ATTR_RVALID_OUT(rv), .ATTR_ERR_OUT(err), .ALARM_OUT(alarm), .WARNING_OUT(warn),
    .ZERO_ACTIVE_OUT(zact), .CAL_SELECT_OUT(cal), .UNITS_SELECT_OUT(units));
  // xorshift source of repeatable values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected alarm level after one sample with zero settling
  function automatic logic aexp(input logic a, input int v);
    if (v > cfg[0] || v < cfg[1])
      return 1'b1;
    if (v >= cfg[1] + cfg[2] && v <= cfg[0] - cfg[2])
      return 1'b0;
    return a;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    checked++;
    if (gt !== ex)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  // one flow sample pulse, then a wait of w cycles
  task automatic samp(input int v, input int w);
    @(negedge clk);
    flow = v;
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
    flow = ~v;
    repeat (w) @(negedge clk);
  endtask
  task automatic rst();
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    rst();
    chk("units_rst", `FMAM_UNITS_PERCENT, units);
    sc_u.rd(`FMAM_ATTR_ZERO_DUR, got, e);
    chk("zero_dur_rst", `FMAM_RST_ZERO_DUR, got);
    foreach (ids[i])
    begin
      got = rnd();
      sc_u.wr(ids[i], got);
      sc_u.rd(ids[i], h0, e);
      chk("rw_attr", got, h0);
    end
    got = rnd();
    sc_u.wr(`FMAM_ATTR_CAL_SEL, got);
    @(negedge clk);
    chk("cal_out", got, cal);
    got = rnd();
    sc_u.wr(`FMAM_ATTR_UNITS, got);
    @(negedge clk);
    chk("units_out", got[15:0], units);
    for (int i = 0; i < 9; i++)
      sc_u.wr(ids[i], cfg[i]);
    a = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      n = (i < 8) ? corner[i] : int'(rnd() % 301) - 150;
      samp(n, 2);
      a = aexp(a, n);
      chk("alarm", a, alarm);
    end
    samp(0, 2);
    samp(60, 4);
    chk("warn_settle", 0, warn);
    samp(0, 0);
    samp(60, 5);
    samp(60, 2);
    chk("warn_restart", 0, warn);
    samp(60, 20);
    samp(60, 2);
    chk("warn_high", 1, warn);
    samp(48, 2);
    chk("warn_hys", 1, warn);
    samp(44, 2);
    chk("warn_clear", 0, warn);
    samp(-60, 20);
    samp(-60, 2);
    chk("warn_low", 1, warn);
    inh = 1'b1;
    sc_u.wr(`FMAM_ATTR_ZERO_START, 32'h1);
    @(negedge clk);
    chk("zero_inhibit", 0, zact);
    inh = 1'b0;
    sc_u.wr(`FMAM_ATTR_ZERO_START, 32'h0);
    @(negedge clk);
    chk("zero_write0", 0, zact);
    sc_u.wr(`FMAM_ATTR_ZERO_START, 32'h1);
    n = 0;
    while (zact === 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk("zero_len", 1, n >= (cfg[8] - 1) * MS && n <= cfg[8] * MS + 1);
    samp(5, 0);
    sc_u.wr(`FMAM_ATTR_FLOW, rnd());
    sc_u.rd(`FMAM_ATTR_FLOW, got, e);
    chk("flow_ro", 5, got);
    chk("rvalid", 1, rv);
    chk("flow_err", 0, e);
    sc_u.rd(8'hFF, got, e);
    chk("unknown_err", 1, e);
    sc_u.rd(`FMAM_ATTR_FLOW_HOURS, h0, e);
    c0 = cycles;
    sc_u.wr(`FMAM_ATTR_FLOW_HOURS, 32'hFFFF0000);
    repeat (60) @(negedge clk);
    sc_u.rd(`FMAM_ATTR_FLOW_HOURS, got, e);
    n = (cycles - c0) / (3 * MS);
    chk("hours", 1, got - h0 >= n - 1 && got - h0 <= n + 1);
    samp(200, 2);
    rst();
    chk("alarm_rst", 0, alarm);
    chk("units_rst2", `FMAM_UNITS_PERCENT, units);
    end_of_test();
  end
endmodule
